// file: common/dpram_host_regs.svh
// register offsets, fields and timing counts of the dual-port ram host controller
`ifndef DPRAM_HOST_REGS_SVH
`define DPRAM_HOST_REGS_SVH
`define HOST_CTRL_OFS 12'h000
`define HOST_ADDR_OFS 12'h004
`define HOST_WDATA_OFS 12'h008
`define HOST_RDATA_OFS 12'h00C
`define HOST_STATUS_OFS 12'h010
`define CTRL_GO_BIT 0
`define CTRL_WRITE_BIT 1
`define CTRL_SEM_BIT 2
`define CTRL_UPPER_BIT 3
`define CTRL_LOWER_BIT 4
`define CTRL_OEWR_BIT 5
`define CTRL_RESET 32'h0000_0018
`define CLK_PERIOD_NS 10
`define T_WRITE_PULSE_NS 12
`define T_WZ_NS 10
`define T_DATA_SETUP_NS 10
`define T_READ_ACCESS_NS 15
`define T_BUSY_DATA_NS 18
`define T_WRITE_HOLD_AFTER_BUSY_NS 12
`define T_SEM_WRITE_TO_READ_NS 5
`define T_ADDR_SETUP_NS 10
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: common/dpram_host_pkg.sv
// types shared by the dual-port ram host controller
package dpram_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_READ,
    ST_GAP
  } host_state_t;
endpackage : dpram_host_pkg

// file: src/dpram_host.sv
// apb-driven host that runs array and semaphore cycles on one port of the dual-port ram
// ==========================================================
// Summary of operation
// RL1: array needs port select low, a lane low, flag select high; flags inverse.
// RL2: hold the chosen selection steady from port select until write end.
// RL3: device writes only lanes whose select is low with port select and write low.
// RL4: address changes only while port select and read/write line are high.
// RL5: device keeps outputs off when select falls with or after write line.
// RL6: with output drive low, pulse is max of pulse width and turnoff plus setup.
// RL7: write data held at least the hold time after the write ends.
// RL8: never drive data onto pins while the device still drives them.
// RL9: read data valid after the last of all access delays.
// RL10: busy-release delay applies only when the other port writes same address.
// RL11: busy-release delay is max of zero and the two port-to-port differences.
// RL12: after a flag write wait write-to-read time; read gives flag on all bits.
// RL13: simultaneous flag releases go to one undefined side.
// RL14: in master mode the earlier stable port wins the address match.
// RL15: busy asserts and releases within the busy access and disable times.
// RL16: a losing port's read or write is blocked until busy returns high.
// RL17: on the losing port keep write active the hold time after busy rises.
// RL18: slave busy input must be asserted no later than the write start.
// RL19: master ignores writes on a port while its busy output is low.
// RL20: eight flags on the three low address bits, written via data bit zero.
// RL21: writing zero to a free flag grants it; release passes it to a waiter.
// RL22: timing and arbitration identical for both ports.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "dpram_host_regs.svh"
module dpram_host
  import dpram_host_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 18
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] address,
  output logic port_select_n,
  output logic read_write_n,
  output logic output_drive_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic flag_select_n,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic busy_n
);
  // ==========================================================
  // timing counts
  localparam int MAX_PULSE_NS = (`T_WZ_NS + `T_DATA_SETUP_NS > `T_WRITE_PULSE_NS) ?
    `T_WZ_NS + `T_DATA_SETUP_NS : `T_WRITE_PULSE_NS;
  localparam logic [3:0] PULSE_CYC = 4'(`CYC_UP(`T_WRITE_PULSE_NS));
  localparam logic [3:0] PULSE_OE_CYC = 4'(`CYC_UP(MAX_PULSE_NS));
  localparam logic [3:0] READ_CYC = 4'(`CYC_UP(`T_READ_ACCESS_NS + `T_BUSY_DATA_NS));
  localparam logic [3:0] HOLD_CYC = 4'(`CYC_UP(`T_WRITE_HOLD_AFTER_BUSY_NS));
  localparam logic [3:0] SETUP_CYC = 4'(`CYC_UP(`T_ADDR_SETUP_NS));
  localparam logic [3:0] GAP_CYC = 4'(`CYC_UP(`T_SEM_WRITE_TO_READ_NS));
  localparam logic [3:0] BDD_CYC = 4'(`CYC_UP(`T_BUSY_DATA_NS));

  // ==========================================================
  // synchronisers for pins
  logic busyMeta_reg;
  logic busySync_reg;
  logic [DATA_W-1:0] dinMeta_reg;
  logic [DATA_W-1:0] dinSync_reg;
  always_ff @(posedge ref_clk)
  begin
    busyMeta_reg <= busy_n;
    busySync_reg <= busyMeta_reg;
    dinMeta_reg <= dataIn;
    dinSync_reg <= dinMeta_reg;
  end

  // ==========================================================
  // registers
  host_state_t state_reg;
  host_state_t state_next;
  logic [5:0] ctrl_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic busySeen_reg;
  logic done_reg;

  wire accessDone = psel && penable;
  wire wrEn = accessDone && pwrite;
  wire idle = (state_reg == ST_IDLE);
  wire goReq = wrEn && (paddr == `HOST_CTRL_OFS) && pwdata[`CTRL_GO_BIT] && idle;
  wire isWrite = ctrl_reg[`CTRL_WRITE_BIT];
  // control as it will stand once a go write lands, so the first cycle selects right
  wire [5:0] ctrlNow = goReq ? {pwdata[5:1], 1'b0} : ctrl_reg;
  wire isSem = ctrlNow[`CTRL_SEM_BIT];
  wire busyLow = !busySync_reg;
  wire countZero = (count_reg == 4'h0);
  wire [3:0] pulseCyc = ctrl_reg[`CTRL_OEWR_BIT] ? PULSE_OE_CYC : PULSE_CYC;

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // register writes; address and data only change while idle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ctrl_reg <= 6'(`CTRL_RESET);
      addr_reg <= '0;
      wdata_reg <= '0;
    end
    else if (wrEn && idle)
    begin
      // RL4: address stable
      if (paddr == `HOST_CTRL_OFS)
        ctrl_reg <= {pwdata[5:1], 1'b0};
      if (paddr == `HOST_ADDR_OFS)
        addr_reg <= pwdata[ADDR_W-1:0];
      if (paddr == `HOST_WDATA_OFS)
        wdata_reg <= pwdata[DATA_W-1:0];
    end
  end

  // ==========================================================
  // cycle sequencer
  always_comb
  begin
    state_next = state_reg;
    count_next = countZero ? 4'h0 : count_reg - 4'h1;
    unique case (state_reg)
      ST_IDLE:
        if (goReq)
        begin
          state_next = ST_SETUP;
          count_next = SETUP_CYC;
        end
      ST_SETUP:
        if (countZero)
        begin
          state_next = isWrite ? ST_PULSE : ST_READ;
          count_next = isWrite ? pulseCyc : READ_CYC;
        end
      ST_PULSE:
        // RL16 RL18 RL22: stretch pulse while busy
        if (busyLow)
          count_next = HOLD_CYC;
        else if (countZero)
        begin
          state_next = ST_HOLD;
          count_next = 4'h1;
        end
      ST_READ:
        // RL9 RL10: wait all access delays, restarted by busy release
        if (busyLow)
          count_next = BDD_CYC;
        else if (countZero)
          state_next = ST_GAP;
      ST_HOLD:
        // RL12: gap before next flag read
        if (countZero)
        begin
          state_next = ST_GAP;
          count_next = GAP_CYC;
        end
      ST_GAP:
        if (countZero)
          state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      count_reg <= 4'h0;
      busySeen_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      // RL17: note contention on the losing port
      if (state_reg == ST_PULSE && busyLow)
        busySeen_reg <= 1'b1;
      else if (goReq)
        busySeen_reg <= 1'b0;
      if (state_reg == ST_READ && state_next == ST_GAP)
        rdata_reg <= dinSync_reg;
      if (state_reg != ST_IDLE && state_next == ST_IDLE)
        done_reg <= 1'b1;
      else if (goReq)
        done_reg <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive, all from flip-flops
  wire active = (state_reg != ST_IDLE);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      address <= '0;
      port_select_n <= 1'b1;
      flag_select_n <= 1'b1;
      upper_lane_select_n <= 1'b1;
      lower_lane_select_n <= 1'b1;
      read_write_n <= 1'b1;
      output_drive_n <= 1'b1;
      dataOut <= '0;
      dataOe <= 1'b0;
    end
    else
    begin
      address <= addr_reg;
      // RL1: array or semaphore select; RL2: held for whole cycle
      port_select_n <= !(state_next != ST_IDLE && state_next != ST_GAP && !isSem);
      flag_select_n <= !(state_next != ST_IDLE && state_next != ST_GAP && isSem);
      upper_lane_select_n <= isSem ? 1'b1 : !ctrlNow[`CTRL_UPPER_BIT];
      lower_lane_select_n <= isSem ? 1'b1 : !ctrlNow[`CTRL_LOWER_BIT];
      // RL6: pulse length set by output drive mode
      read_write_n <= !(state_next == ST_PULSE);
      output_drive_n <= !((state_next == ST_READ) ||
        (state_next == ST_PULSE && ctrl_reg[`CTRL_OEWR_BIT]));
      // RL7: data kept through hold; RL8: drive only in a write
      dataOut <= wdata_reg;
      dataOe <= (state_next == ST_PULSE) || (state_next == ST_HOLD);
    end
  end

  // ==========================================================
  // read mux
  wire [31:0] statusWord = {28'h0, busySeen_reg, busySync_reg, done_reg, active};
  assign prdata = (paddr == `HOST_CTRL_OFS) ? {26'h0, ctrl_reg} :
    (paddr == `HOST_ADDR_OFS) ? 32'(addr_reg) :
    (paddr == `HOST_WDATA_OFS) ? 32'(wdata_reg) :
    (paddr == `HOST_RDATA_OFS) ? 32'(rdata_reg) :
    (paddr == `HOST_STATUS_OFS) ? statusWord : 32'h0;
endmodule : dpram_host

// file: tb/dpram_host_properties.sv
// pin sequencing checks of the dual-port ram host
`timescale 1ns/10ps
module dpram_host_properties
  import dpram_host_pkg::*;
#(parameter int ADDR_W = 12, parameter int DATA_W = 18)
(
  input logic ref_clk,
  input logic reset,
  input logic [ADDR_W-1:0] address,
  input logic port_select_n,
  input logic read_write_n,
  input logic output_drive_n,
  input logic upper_lane_select_n,
  input logic lower_lane_select_n,
  input logic flag_select_n,
  input logic [DATA_W-1:0] dataOut,
  input logic dataOe,
  input logic busy_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire [3:0] sel = {port_select_n, flag_select_n, upper_lane_select_n, lower_lane_select_n};
  sequence s_pulse_on; $fell(read_write_n); endsequence
  sequence s_pulse_off; $rose(read_write_n); endsequence
  property p_array_sel; !port_select_n |-> flag_select_n && sel[1:0] != 2'h3; endproperty
  a_array_sel: assert property (p_array_sel) else $error("array select");
  property p_flag_sel; !flag_select_n |-> sel[3] && sel[1:0] == 2'h3; endproperty
  a_flag_sel: assert property (p_flag_sel) else $error("flag select");
  property p_addr_move; !$stable(address) |-> read_write_n && $past(read_write_n); endproperty
  a_addr_move: assert property (p_addr_move) else $error("address moved in write");
  property p_sel_hold; !$past(read_write_n) |-> $stable(sel); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed in write");
  property p_sel_steady;
    !(port_select_n && flag_select_n) && $past(!(port_select_n && flag_select_n)) |-> $stable(sel);
  endproperty
  a_sel_steady: assert property (p_sel_steady) else $error("selection changed in cycle");
  property p_pulse_len; s_pulse_on |=> !read_write_n; endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("write pulse short");
  property p_data_hold; s_pulse_off |-> dataOe && $stable(dataOut); endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held");
  property p_no_fight; !output_drive_n && read_write_n |-> !dataOe; endproperty
  a_no_fight: assert property (p_no_fight) else $error("pins driven in read");
  property p_busy_hold; s_pulse_off |-> $past(busy_n) && $past(busy_n, 2); endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write ended near busy");
endmodule : dpram_host_properties
bind dpram_host dpram_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .ref_clk, .reset, .address, .port_select_n, .read_write_n, .output_drive_n,
  .upper_lane_select_n, .lower_lane_select_n, .flag_select_n, .dataOut, .dataOe, .busy_n);

// file: tb/dpram_device_model.sv
// behavioural dual-port ram with a scripted opposite port
`timescale 1ns/10ps
module dpram_device_model
  import dpram_host_pkg::*;
(
  input logic ref_clk,
  input logic [11:0] address,
  input logic port_select_n,
  input logic read_write_n,
  input logic output_drive_n,
  input logic upper_lane_select_n,
  input logic lower_lane_select_n,
  input logic flag_select_n,
  input logic [17:0] dataOut,
  input logic dataOe,
  output logic [17:0] dataIn,
  output logic busy_n
);
  logic [17:0] mem [4096];
  int own [8] = '{default: -1};
  bit pend [8][2];
  logic [17:0] junk = 18'h2AAAA;
  logic [17:0] devOut;
  logic devDrv;
  logic otherAct = 1'b0;
  // slave busy raised before the host starts
  assign busy_n = !otherAct;
  // outputs only in a read, after access time
  assign #15 devDrv = read_write_n && !output_drive_n && !(port_select_n && flag_select_n)
    && !otherAct;
  assign #15 devOut = flag_select_n ? mem[address] : {18{own[address[2:0]] != 0}};
  // released pins show a toggling pattern
  assign dataIn = dataOe ? dataOut : devDrv ? devOut : junk;
  always @(posedge ref_clk) junk <= ~junk;
  // zero takes a free flag, release hands it over
  function automatic void semW(input int s, input int i, input logic v);
    if (!v && own[i] < 0) own[i] = s;
    else if (!v && own[i] != s) pend[i][s] = 1;
    else if (v && own[i] == s)
    begin
      own[i] = pend[i][1-s] ? 1 - s : -1;
      pend[i][1-s] = 0;
    end
  endfunction : semW
  // selected lanes written at pulse end unless busy
  always @(posedge read_write_n)
  begin
    if (!port_select_n && flag_select_n && !otherAct)
    begin
      if (!lower_lane_select_n) mem[address][8:0] = dataOut[8:0];
      if (!upper_lane_select_n) mem[address][17:9] = dataOut[17:9];
    end
    if (!flag_select_n) semW(0, address[2:0], dataOut[0]);
  end
  // opposite port holds busy, its write lands on release
  task automatic hold(input logic [11:0] a, input logic [17:0] d, input int n);
    otherAct <= 1'b1;
    repeat (n) @(posedge ref_clk);
    mem[a] = d;
    otherAct <= 1'b0;
  endtask : hold
endmodule : dpram_device_model

// file: tb/dpram_host_test.sv
// apb tests of the dual-port ram host against the device model
`timescale 1ns/10ps
`include "dpram_host_regs.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module dpram_host_test
  import dpram_host_pkg::*;
();
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000, address;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [17:0] dataIn, dataOut;
  logic pready, pslverr, port_select_n, read_write_n, output_drive_n, dataOe, busy_n;
  logic upper_lane_select_n, lower_lane_select_n, flag_select_n;
  int err_total = 0, n_compared = 0;
  time t0, tOp;
  dpram_host u_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .address(address), .port_select_n(port_select_n),
    .read_write_n(read_write_n), .output_drive_n(output_drive_n),
    .upper_lane_select_n(upper_lane_select_n), .lower_lane_select_n(lower_lane_select_n),
    .flag_select_n(flag_select_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .busy_n(busy_n));
  dpram_device_model u_dev (.ref_clk(ref_clk), .address(address),
    .port_select_n(port_select_n), .read_write_n(read_write_n),
    .output_drive_n(output_drive_n), .upper_lane_select_n(upper_lane_select_n),
    .lower_lane_select_n(lower_lane_select_n), .flag_select_n(flag_select_n),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .busy_n(busy_n));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic [31:0] ctrl, input logic [11:0] a, input logic [31:0] d);
    int n;
    apb(1, `HOST_ADDR_OFS, {20'h00000, a});
    apb(1, `HOST_WDATA_OFS, d);
    apb(1, `HOST_CTRL_OFS, ctrl);
    n = 0;
    do apb(0, `HOST_STATUS_OFS, 32'h0); while (rd[1] !== 1'b1 && ++n < 200);
    if (n >= 200)
    begin
      err_total++;
      report_and_stop();
    end
    apb(0, `HOST_RDATA_OFS, 32'h0);
  endtask : op
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    apb(0, `HOST_CTRL_OFS, 32'h0);
    `CHK("ctrl", `CTRL_RESET, rd)
    apb(0, `HOST_STATUS_OFS, 32'h0);
    `CHK("status", 32'h0000_0004, rd)
    apb(0, 12'h020, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("slverr", 1'b0, pslverr)
    $display("reset test done");
    op(32'h0000_001B, 12'h123, 32'h0002_ABCD);
    op(32'h0000_0019, 12'h123, 32'h0);
    `CHK("both lanes", 18'h2ABCD, rd[17:0])
    op(32'h0000_0013, 12'h123, 32'h0003_FE55);
    op(32'h0000_0019, 12'h123, 32'h0);
    `CHK("lower lane", 18'h2AA55, rd[17:0])
    op(32'h0000_003B, 12'hFFF, 32'h0003_FFFF);
    op(32'h0000_0019, 12'hFFF, 32'h0);
    `CHK("drive write", 18'h3FFFF, rd[17:0])
    $display("array test done");
    op(32'h0000_0007, 12'h003, 32'h0);
    u_dev.semW(1, 3, 1'b0);
    op(32'h0000_0007, 12'h003, 32'h1);
    op(32'h0000_0005, 12'h003, 32'h0);
    `CHK("flag to other", 18'h3FFFF, rd[17:0])
    op(32'h0000_0007, 12'h003, 32'h0);
    u_dev.semW(1, 3, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      op(32'h0000_0005, i[11:0], 32'h0);
      `CHK("flag", i == 3 ? 18'h00000 : 18'h3FFFF, rd[17:0])
    end
    $display("flag test done");
    t0 = $time;
    fork
      u_dev.hold(12'h123, 18'h0AAAA, 30);
      begin
        op(32'h0000_001B, 12'h123, 32'h0001_1111);
        tOp = $time;
      end
    join
    `CHK("blocked", 1'b1, tOp > t0 + 300)
    apb(0, `HOST_STATUS_OFS, 32'h0);
    `CHK("busy seen", 1'b1, rd[3])
    op(32'h0000_0019, 12'h123, 32'h0);
    `CHK("write after busy", 18'h11111, rd[17:0])
    fork
      u_dev.hold(12'h200, 18'h0F0F0, 30);
      op(32'h0000_0019, 12'h200, 32'h0);
    join
    `CHK("port to port", 18'h0F0F0, rd[17:0])
    $display("busy test done");
    report_and_stop();
  end
endmodule : dpram_host_test
